// *** src/afepc_consts.svh ***
`ifndef AFEPC_CONSTS_SVH
`define AFEPC_CONSTS_SVH

// register indices; byte address is four times the index
`define AFEPC_IDX_CFG        6'h05
`define AFEPC_IDX_GAIN_R     6'h06
`define AFEPC_IDX_GAIN_G     6'h07
`define AFEPC_IDX_GAIN_B     6'h08
`define AFEPC_IDX_POWER      6'h1b
`define AFEPC_IDX_TUNING     6'h1c
`define AFEPC_IDX_CLAMP      6'h23
`define AFEPC_IDX_OFS_R      6'h30
`define AFEPC_IDX_OFS_G      6'h31
`define AFEPC_IDX_OFS_B      6'h32
`define AFEPC_IDX_SERVO      6'h33
`define AFEPC_IDX_PPL        6'h34
`define AFEPC_IDX_PHASE      6'h35
`define AFEPC_IDX_DAC_R      6'h36
`define AFEPC_IDX_DAC_G      6'h37
`define AFEPC_IDX_DAC_B      6'h38
`define AFEPC_IDX_PLL_STAT   6'h39

// reset values
`define AFEPC_CFG_RST        8'h00
`define AFEPC_GAIN_RST       8'h55
`define AFEPC_POWER_RST      8'h00
`define AFEPC_TUNING_RST     8'h47
`define AFEPC_CLAMP_RST      8'h08
`define AFEPC_OFS_RST        8'h80
`define AFEPC_SERVO_RST      8'h41
`define AFEPC_PPL_RST        12'h320
`define AFEPC_PHASE_RST      6'h00
`define AFEPC_DAC_RST        10'h200
`define AFEPC_NCO_RST        32'h40000000

// field positions
`define AFEPC_CFG_YUV_BIT    2
`define AFEPC_SRV_EN_BIT     0
`define AFEPC_SRV_PIX_LSB    2
`define AFEPC_SRV_BW_LSB     4
`define AFEPC_CLAMP_R_LSB    4
`define AFEPC_PLL_PD_BIT     3

// levels and steps
`define AFEPC_BLACK_RGB      8'h00
`define AFEPC_BLACK_YUV      8'h80
`define AFEPC_OFS_SPAN       9'sd64
`define AFEPC_NCO_STEP       32'h00001000

`endif

// *** src/afepc_pkg.sv ***
package afepc_pkg;

  typedef enum logic [1:0] {
    AFEPC_SRV_IDLE = 2'b00,
    AFEPC_SRV_ACC  = 2'b01,
    AFEPC_SRV_EVAL = 2'b10
  } afepc_srv_e;

  typedef logic [9:0] afepc_dac_t;

endpackage

// *** src/afepc_servo_if.sv ***
`timescale 1ns/1ps
interface afepc_servo_if;
  import afepc_pkg::*;
  logic       enable;
  logic       hold;
  logic       line_evt;
  logic       pix_vld;
  logic [7:0] pix_code;
  logic [1:0] pix_sel;
  logic [2:0] bw_sel;
  logic [7:0] target;
  afepc_dac_t fw_dac;
  afepc_dac_t dac;

  modport ctl (output enable, hold, line_evt, pix_vld, pix_code, pix_sel, bw_sel, target, fw_dac, input dac);
  modport srv (input enable, hold, line_evt, pix_vld, pix_code, pix_sel, bw_sel, target, fw_dac, output dac);
endinterface

// *** src/afepc_servo.sv ***
`timescale 1ns/1ps
`include "afepc_consts.svh"
module afepc_servo
  import afepc_pkg::*;
(
  input  wire logic   hclk,    // system clock
  input  wire logic   hresetn, // async reset
  afepc_servo_if.srv  sif      // per-channel servo link
);

  afepc_srv_e  st_q;
  logic [14:0] sum_q;
  logic [7:0]  cnt_q;
  logic [11:0] line_q;
  logic [11:0] line_lim;
  logic [7:0]  pix_lim;
  logic [7:0]  avg;
  afepc_dac_t  dac_q;

  assign pix_lim  = 8'h10 << sif.pix_sel;
  assign line_lim = 12'(13'h020 << sif.bw_sel) - 12'h001;
  assign avg      = 8'(sum_q >> (3'd4 + 3'(sif.pix_sel)));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q  <= AFEPC_SRV_IDLE;
      sum_q <= 15'h0000;
      cnt_q <= 8'h00;
    end else begin
      unique case (st_q)
        AFEPC_SRV_IDLE: begin
          if (sif.line_evt && sif.enable && !sif.hold) begin
            st_q  <= AFEPC_SRV_ACC;
            sum_q <= 15'h0000;
            cnt_q <= 8'h00;
          end
        end
        AFEPC_SRV_ACC: begin
          if (!sif.enable || sif.hold) begin
            st_q <= AFEPC_SRV_IDLE;
          // short line dropped, never averaged across lines
          end else if (sif.line_evt) begin
            sum_q <= 15'h0000;
            cnt_q <= 8'h00;
          end else if (sif.pix_vld) begin
            sum_q <= sum_q + 15'(sif.pix_code);
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q + 8'h01 == pix_lim) begin
              st_q <= AFEPC_SRV_EVAL;
            end
          end
        end
        AFEPC_SRV_EVAL: st_q <= AFEPC_SRV_IDLE;
        default:        st_q <= AFEPC_SRV_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_q <= 12'h000;
      dac_q  <= `AFEPC_DAC_RST;
    end else if (!sif.enable) begin
      dac_q  <= sif.fw_dac;
      line_q <= 12'h000;
    end else if (st_q == AFEPC_SRV_EVAL && !sif.hold) begin
      if (line_q >= line_lim) begin
        line_q <= 12'h000;
        if (avg > sif.target && dac_q != 10'h000) begin
          dac_q <= dac_q - 10'h001;
        end else if (avg < sif.target && dac_q != 10'h3ff) begin
          dac_q <= dac_q + 10'h001;
        end
      end else begin
        line_q <= line_q + 12'h001;
      end
    end
  end

  assign sif.dac = dac_q;

  chk_servo_step: assert property (@(posedge hclk) disable iff (!hresetn)
    sif.enable && $past(sif.enable) |-> (dac_q == $past(dac_q) || dac_q == $past(dac_q) + 10'h001 ||
                                         dac_q == $past(dac_q) - 10'h001))
    else $error("servo stepped more than one dac lsb");

  chk_servo_fw: assert property (@(posedge hclk) disable iff (!hresetn)
    !sif.enable |=> dac_q == $past(sif.fw_dac))
    else $error("disabled servo did not pass firmware dac");

  chk_servo_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    sif.enable && sif.hold ##1 sif.enable |-> $stable(dac_q))
    else $error("servo moved while channel powered down");

  chk_servo_rate: assert property (@(posedge hclk) disable iff (!hresetn)
    sif.enable && $past(sif.enable) && st_q != AFEPC_SRV_IDLE |-> $stable(dac_q))
    else $error("servo updated outside evaluation");

endmodule // afepc_servo

// *** src/afepc_ctrl.sv ***
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "afepc_consts.svh"
// What this block does
// - power bits 0..2 shut each converter
// - power bit 3 shuts pixel pll
// - three-bit clamp resistance, zero disconnects
// - sixty-four sampling phases per pixel
// - pixel clock from numerically controlled oscillator
// - pll self-locks given pixels per line
// - servo nulls black level per channel
// - quarter-lsb steps, still when locked
// - manual offset plus/minus 64 codes
// - servo disable hands dacs to firmware
// - three gain registers, offset unaffected
// - black code 0x00, 0x80 for chroma
// - dac lsb weight independent of gain
// - 16 to 128 black pixels averaged
// - time constant two to five-plus-field lines
// - config bit 2 selects yuv mode
// - gain loads only on clamp event
module afepc_ctrl
  import afepc_pkg::*;
(
  input  wire logic        hclk,         // system clock, 100 MHz
  input  wire logic        hresetn,      // async reset, active low
  input  wire logic        hsel,         // ahb slave select
  input  wire logic [31:0] haddr,        // ahb address
  input  wire logic [1:0]  htrans,       // ahb transfer type
  input  wire logic        hwrite,       // ahb write
  input  wire logic [2:0]  hsize,        // ahb size
  input  wire logic [31:0] hwdata,       // ahb write data
  input  wire logic        hready,       // ahb bus ready
  output logic      [31:0] hrdata,       // ahb read data
  output logic             hreadyout,    // ahb slave ready
  output logic             hresp,        // ahb response
  input  wire logic        line_sync,    // per-line clamp event pin
  input  wire logic        black_vld,    // black-pixel strobe pin
  input  wire logic [23:0] adc_code,     // b,g,r converter codes
  output logic      [2:0]  adc_pd,       // converter power-down b,g,r
  output logic             pll_pd,       // pixel pll power-down
  output logic      [2:0]  clamp_code,   // clamp on-resistance code
  output logic      [7:0]  tuning,       // tuning register value
  output logic      [23:0] gain_live,    // gains applied b,g,r
  output logic      [29:0] offset_dac,   // offset dacs b,g,r
  output logic      [5:0]  sample_phase, // sampling phase step
  output logic             pix_tick,     // nco pixel strobe
  output logic             pll_locked,   // nco lock indicator
  output logic             yuv_mode      // yuv processing on
);

  logic [7:0]  cfg_q;
  logic [7:0]  power_q;
  logic [7:0]  tuning_q;
  logic [7:0]  clamp_q;
  logic [7:0]  servo_q;
  logic [11:0] ppl_q;
  logic [5:0]  phase_q;
  logic [23:0] gain_q;
  logic [23:0] gain_live_q;
  logic [23:0] ofs_q;
  logic [29:0] fw_dac_q;
  logic [29:0] dac_w;
  logic        wr_pend_q;
  logic [5:0]  wr_idx_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_val;
  logic [2:0]  ls_sync_q;
  logic [1:0]  bv_sync_q;
  logic [23:0] code_m_q;
  logic [23:0] code_q;
  logic        line_evt_q;
  logic [31:0] nco_acc_q;
  logic [31:0] nco_inc_q;
  logic [11:0] pix_cnt_q;
  logic        tick_q;
  logic        locked_q;
  logic        addr_ok;
  logic        hreadyout_q;
  logic        hresp_q;

  function automatic logic [7:0] black_target(input logic [1:0] ch, input logic yuv, input logic [7:0] ofs);
    logic signed [9:0] t;
    logic signed [9:0] d;
    t = (yuv && ch != 2'd1) ? 10'(`AFEPC_BLACK_YUV) : 10'(`AFEPC_BLACK_RGB);
    d = 10'($signed({2'b00, ofs}) - 10'sh080);
    if (d > 10'(`AFEPC_OFS_SPAN)) d = 10'(`AFEPC_OFS_SPAN);
    if (d < -10'(`AFEPC_OFS_SPAN)) d = -10'(`AFEPC_OFS_SPAN);
    t = t + d;
    if (t < 10'sd0) t = 10'sd0;
    if (t > 10'sd255) t = 10'sd255;
    return t[7:0];
  endfunction

  function automatic logic [1:0] idx_lane(input logic [5:0] idx, input logic [5:0] base);
    return 2'(idx - base);
  endfunction

  // ahb: zero wait states, always okay
  assign addr_ok = hsel && hready && htrans[1];

  // bus answer flops so the outputs come from registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 6'h00;
      hrdata_q  <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q  <= haddr[7:2];
      if (addr_ok && !hwrite) begin
        hrdata_q <= (haddr[31:8] == 24'h000000) ? rd_val : 32'h00000000;
      end
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    unique case (haddr[7:2])
      `AFEPC_IDX_CFG:      rd_val = {24'h000000, cfg_q};
      `AFEPC_IDX_GAIN_R,
      `AFEPC_IDX_GAIN_G,
      `AFEPC_IDX_GAIN_B:   rd_val = {24'h000000, gain_q[8*idx_lane(haddr[7:2], `AFEPC_IDX_GAIN_R) +: 8]};
      `AFEPC_IDX_POWER:    rd_val = {24'h000000, power_q};
      `AFEPC_IDX_TUNING:   rd_val = {24'h000000, tuning_q};
      `AFEPC_IDX_CLAMP:    rd_val = {24'h000000, clamp_q};
      `AFEPC_IDX_OFS_R,
      `AFEPC_IDX_OFS_G,
      `AFEPC_IDX_OFS_B:    rd_val = {24'h000000, ofs_q[8*idx_lane(haddr[7:2], `AFEPC_IDX_OFS_R) +: 8]};
      `AFEPC_IDX_SERVO:    rd_val = {24'h000000, servo_q};
      `AFEPC_IDX_PPL:      rd_val = {20'h00000, ppl_q};
      `AFEPC_IDX_PHASE:    rd_val = {26'h0, phase_q};
      `AFEPC_IDX_DAC_R,
      `AFEPC_IDX_DAC_G,
      `AFEPC_IDX_DAC_B:    rd_val = {22'h0, dac_w[10*idx_lane(haddr[7:2], `AFEPC_IDX_DAC_R) +: 10]};
      `AFEPC_IDX_PLL_STAT: rd_val = {nco_inc_q[31:1], locked_q};
      default:             rd_val = 32'h00000000;
    endcase
  end

  // register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q    <= `AFEPC_CFG_RST;
      power_q  <= `AFEPC_POWER_RST;
      tuning_q <= `AFEPC_TUNING_RST;
      clamp_q  <= `AFEPC_CLAMP_RST;
      servo_q  <= `AFEPC_SERVO_RST;
      ppl_q    <= `AFEPC_PPL_RST;
      phase_q  <= `AFEPC_PHASE_RST;
      gain_q   <= {3{`AFEPC_GAIN_RST}};
      ofs_q    <= {3{`AFEPC_OFS_RST}};
      fw_dac_q <= {3{`AFEPC_DAC_RST}};
    end else if (wr_pend_q) begin
      unique case (wr_idx_q)
        `AFEPC_IDX_CFG:    cfg_q    <= hwdata[7:0];
        `AFEPC_IDX_GAIN_R,
        `AFEPC_IDX_GAIN_G,
        `AFEPC_IDX_GAIN_B: gain_q[8*idx_lane(wr_idx_q, `AFEPC_IDX_GAIN_R) +: 8] <= hwdata[7:0];
        `AFEPC_IDX_POWER:  power_q  <= hwdata[7:0];
        `AFEPC_IDX_TUNING: tuning_q <= hwdata[7:0];
        `AFEPC_IDX_CLAMP:  clamp_q  <= hwdata[7:0];
        `AFEPC_IDX_OFS_R,
        `AFEPC_IDX_OFS_G,
        `AFEPC_IDX_OFS_B:  ofs_q[8*idx_lane(wr_idx_q, `AFEPC_IDX_OFS_R) +: 8] <= hwdata[7:0];
        `AFEPC_IDX_SERVO:  servo_q  <= hwdata[7:0];
        `AFEPC_IDX_PPL:    ppl_q    <= hwdata[11:0];
        `AFEPC_IDX_PHASE:  phase_q  <= hwdata[5:0];
        `AFEPC_IDX_DAC_R,
        `AFEPC_IDX_DAC_G,
        `AFEPC_IDX_DAC_B:  fw_dac_q[10*idx_lane(wr_idx_q, `AFEPC_IDX_DAC_R) +: 10] <= hwdata[9:0];
        default: ;
      endcase
    end
  end

  // pin synchronisers and clamp event edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ls_sync_q  <= 3'h0;
      bv_sync_q  <= 2'h0;
      code_m_q   <= 24'h000000;
      code_q     <= 24'h000000;
      line_evt_q <= 1'b0;
    end else begin
      ls_sync_q  <= {ls_sync_q[1:0], line_sync};
      bv_sync_q  <= {bv_sync_q[0], black_vld};
      code_m_q   <= adc_code;
      code_q     <= code_m_q;
      line_evt_q <= ls_sync_q[1] && !ls_sync_q[2];
    end
  end

  // gain shadow loads on clamp event
  // gain has no path to the offset dacs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_live_q <= {3{`AFEPC_GAIN_RST}};
    end else if (line_evt_q) begin
      gain_live_q <= gain_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nco_acc_q <= 32'h00000000;
      nco_inc_q <= `AFEPC_NCO_RST;
      pix_cnt_q <= 12'h000;
      tick_q    <= 1'b0;
      locked_q  <= 1'b0;
    end else if (power_q[`AFEPC_PLL_PD_BIT]) begin
      tick_q    <= 1'b0;
      locked_q  <= 1'b0;
      pix_cnt_q <= 12'h000;
    end else begin
      {tick_q, nco_acc_q} <= {1'b0, nco_acc_q} + {1'b0, nco_inc_q};
      if (line_evt_q) begin
        pix_cnt_q <= 12'h000;
        locked_q  <= (pix_cnt_q == ppl_q);
        if (pix_cnt_q < ppl_q && nco_inc_q < 32'hffffffff - `AFEPC_NCO_STEP) begin
          nco_inc_q <= nco_inc_q + `AFEPC_NCO_STEP;
        end else if (pix_cnt_q > ppl_q && nco_inc_q > `AFEPC_NCO_STEP) begin
          nco_inc_q <= nco_inc_q - `AFEPC_NCO_STEP;
        end
      end else if (tick_q && pix_cnt_q != 12'hfff) begin
        pix_cnt_q <= pix_cnt_q + 12'h001;
      end
    end
  end

  afepc_servo_if sif [3] ();

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_ch
      assign sif[ch].enable   = servo_q[`AFEPC_SRV_EN_BIT];
      assign sif[ch].hold     = power_q[ch];
      assign sif[ch].line_evt = line_evt_q;
      assign sif[ch].pix_vld  = bv_sync_q[1];
      assign sif[ch].pix_code = code_q[8*ch +: 8];
      assign sif[ch].pix_sel  = servo_q[`AFEPC_SRV_PIX_LSB +: 2];
      assign sif[ch].bw_sel   = servo_q[`AFEPC_SRV_BW_LSB +: 3];
      assign sif[ch].target   = black_target(2'(ch), cfg_q[`AFEPC_CFG_YUV_BIT], ofs_q[8*ch +: 8]);
      assign sif[ch].fw_dac   = fw_dac_q[10*ch +: 10];
      assign dac_w[10*ch +: 10] = sif[ch].dac;
      afepc_servo u_servo (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sif     (sif[ch])
      );
    end
  endgenerate

  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = hresp_q;
  assign adc_pd       = power_q[2:0];
  assign pll_pd       = power_q[`AFEPC_PLL_PD_BIT];
  assign clamp_code   = clamp_q[`AFEPC_CLAMP_R_LSB +: 3];
  assign tuning       = tuning_q;
  assign gain_live    = gain_live_q;
  assign offset_dac   = dac_w;
  assign sample_phase = phase_q;
  assign pix_tick     = tick_q;
  assign pll_locked   = locked_q;
  assign yuv_mode     = cfg_q[`AFEPC_CFG_YUV_BIT];

  chk_power_adc: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_idx_q == `AFEPC_IDX_POWER |=> adc_pd == $past(hwdata[2:0]))
    else $error("converter power-down not taken from write");

  chk_power_pll: assert property (@(posedge hclk) disable iff (!hresetn)
    pll_pd |=> !pix_tick && !pll_locked)
    else $error("pll ran while powered down");

  chk_clamp_code: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_idx_q == `AFEPC_IDX_CLAMP |=> clamp_code == $past(hwdata[6:4]))
    else $error("clamp code not taken from bits 6:4");

  chk_phase_set: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_idx_q == `AFEPC_IDX_PHASE |=> sample_phase == $past(hwdata[5:0]))
    else $error("sampling phase not taken from write");

  chk_gain_event: assert property (@(posedge hclk) disable iff (!hresetn)
    !line_evt_q |=> $stable(gain_live))
    else $error("gain changed without clamp event");

  chk_gain_load: assert property (@(posedge hclk) disable iff (!hresetn)
    line_evt_q |=> gain_live == $past(gain_q))
    else $error("gain not loaded on clamp event");

  chk_lock_match: assert property (@(posedge hclk) disable iff (!hresetn)
    line_evt_q && !pll_pd |=> pll_locked == ($past(pix_cnt_q) == $past(ppl_q)))
    else $error("lock flag disagrees with pixel count");

  chk_yuv_target: assert property (@(posedge hclk) disable iff (!hresetn)
    yuv_mode && ofs_q[7:0] == `AFEPC_OFS_RST |-> sif[0].target == `AFEPC_BLACK_YUV)
    else $error("red chroma target not mid-scale in yuv");

  chk_black_rgb: assert property (@(posedge hclk) disable iff (!hresetn)
    ofs_q[15:8] == `AFEPC_OFS_RST |-> sif[1].target == `AFEPC_BLACK_RGB)
    else $error("luma target not zero at nominal offset");

  chk_ofs_span: assert property (@(posedge hclk) disable iff (!hresetn)
    !yuv_mode |-> sif[0].target <= 8'h40)
    else $error("manual offset beyond 64 codes");

  chk_yuv_set: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_idx_q == `AFEPC_IDX_CFG |=> yuv_mode == $past(hwdata[`AFEPC_CFG_YUV_BIT]))
    else $error("yuv mode not taken from config bit 2");

  chk_ppl_set: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_idx_q == `AFEPC_IDX_PPL |=> ppl_q == $past(hwdata[11:0]))
    else $error("pixels per line not taken from write");

  chk_gain_offset: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_idx_q >= `AFEPC_IDX_GAIN_R && wr_idx_q <= `AFEPC_IDX_GAIN_B && !servo_q[`AFEPC_SRV_EN_BIT] &&
    !$past(servo_q[`AFEPC_SRV_EN_BIT]) && $stable(fw_dac_q) |=> $stable(offset_dac))
    else $error("gain write moved an offset dac");

endmodule // afepc_ctrl

// *** testbench/afepc_video_src.sv ***
`timescale 1ns/1ps
module afepc_video_src (
  input  wire logic        hclk,      // sampling clock
  output logic             line_sync, // once-per-line sync
  output logic             black_vld, // back-porch strobe
  output logic      [23:0] adc_code   // b,g,r codes
);
  logic [23:0] black_lvl;

  initial begin
    line_sync = 1'b0;
    black_vld = 1'b0;
    adc_code  = 24'h5a3c96;
    black_lvl = 24'h000000;
  end

  // sync then black samples per line
  task automatic send_lines(input int nlines, input int npix);
    @(posedge hclk);
    for (int l = 0; l < nlines; l++) begin
      line_sync <= 1'b1;
      repeat (4) @(posedge hclk);
      line_sync <= 1'b0;
      repeat (4) @(posedge hclk);
      repeat (npix) begin
        black_vld <= 1'b1;
        adc_code  <= black_lvl;
        @(posedge hclk);
      end
      black_vld <= 1'b0;
      // active video toggles so stale samples show
      repeat (12) begin
        adc_code <= ~adc_code;
        @(posedge hclk);
      end
    end
  endtask
endmodule // afepc_video_src

// *** testbench/tb_afe_power_clamp_black_level_control.sv ***
`timescale 1ns/1ps
`include "afepc_consts.svh"
module tb_afe_power_clamp_black_level_control;
  import afepc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        pll_pd, pix_tick, pll_locked, yuv_mode, line_sync, black_vld;
  logic [1:0]  htrans;
  logic [2:0]  hsize, adc_pd, clamp_code;
  logic [5:0]  sample_phase;
  logic [7:0]  tuning;
  logic [23:0] adc_code, gain_live;
  logic [29:0] offset_dac;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          miscompares, n_tests;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  afepc_ctrl DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_sync(line_sync), .black_vld(black_vld),
    .adc_code(adc_code), .adc_pd(adc_pd), .pll_pd(pll_pd), .clamp_code(clamp_code),
    .tuning(tuning), .gain_live(gain_live), .offset_dac(offset_dac),
    .sample_phase(sample_phase), .pix_tick(pix_tick), .pll_locked(pll_locked), .yuv_mode(yuv_mode)
  );

  afepc_video_src SRC (
    .hclk(hclk), .line_sync(line_sync), .black_vld(black_vld), .adc_code(adc_code)
  );

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check_port(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      $display("BAD %0t bus hang", $time);
      stop_test();
    end
  endtask

  task automatic ahb_write(input logic [5:0] idx, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr  <= {24'h0, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic ahb_read(input logic [5:0] idx, output logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= 1'b0;
    haddr  <= {24'h0, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    wait_ready();
    d = hrdata;
  endtask

  task automatic check_reg(input logic [5:0] idx, input logic [31:0] exp);
    ahb_read(idx, rd);
    check_port(rd, exp, "register read");
  endtask

  task automatic count_ticks(output int c);
    c = 0;
    repeat (40) begin
      @(posedge hclk);
      #1;
      if (pix_tick === 1'b1) c++;
    end
  endtask

  task automatic t_reset();
    #1;
    check_port(32'({adc_pd, pll_pd, clamp_code, yuv_mode, sample_phase}), 32'h0, "reset outs");
    check_port(32'(tuning), 32'h47, "reset tuning");
    check_port(32'(gain_live), 32'h555555, "reset gains");
    check_port(32'(offset_dac), 32'({3{10'h200}}), "reset dacs");
    check_reg(`AFEPC_IDX_POWER, 32'h0);
    check_reg(`AFEPC_IDX_TUNING, 32'h47);
    check_reg(`AFEPC_IDX_CLAMP, 32'h08);
    check_reg(`AFEPC_IDX_SERVO, 32'h41);
    check_reg(`AFEPC_IDX_OFS_R, 32'h80);
    check_reg(`AFEPC_IDX_PPL, 32'h320);
    ahb_write(`AFEPC_IDX_PPL, 32'h1f4);
    check_reg(`AFEPC_IDX_PPL, 32'h1f4);
    ahb_write(6'h3f, 32'hff);
    check_reg(6'h3f, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_power();
    int c;
    for (int i = 0; i < 4; i++) begin
      ahb_write(`AFEPC_IDX_POWER, 32'(1 << i));
      settle(1);
      check_port(32'({pll_pd, adc_pd}), 32'(1 << i), "power bits");
    end
    settle(2);
    count_ticks(c);
    check_port(32'(c), 32'h0, "ticks while pll down");
    SRC.send_lines(2, 16);
    settle(10);
    check_port(32'(pll_locked), 32'h0, "lock while pll down");
    check_reg(`AFEPC_IDX_POWER, 32'h08);
    ahb_write(`AFEPC_IDX_POWER, 32'h0);
    settle(2);
    count_ticks(c);
    check_port(32'(c != 0), 32'h1, "ticks while pll up");
    $display("test power done");
  endtask

  task automatic t_tune_clamp();
    ahb_write(`AFEPC_IDX_TUNING, 32'h49);
    settle(1);
    check_port(32'(tuning), 32'h49, "tuning out");
    for (int k = 0; k < 8; k++) begin
      ahb_write(`AFEPC_IDX_CLAMP, 32'({k[2:0], 4'h8}));
      settle(1);
      check_port(32'(clamp_code), 32'(k), "clamp code");
      check_reg(`AFEPC_IDX_CLAMP, 32'({k[2:0], 4'h8}));
    end
    ahb_write(`AFEPC_IDX_PHASE, 32'h3f);
    settle(1);
    check_port(32'(sample_phase), 32'h3f, "last phase");
    ahb_write(`AFEPC_IDX_CFG, 32'h04);
    settle(1);
    check_port(32'(yuv_mode), 32'h1, "yuv on");
    ahb_write(`AFEPC_IDX_CFG, 32'h00);
    settle(1);
    check_port(32'(yuv_mode), 32'h0, "yuv off");
    $display("test tuning clamp done");
  endtask

  task automatic t_fw_gain();
    ahb_write(`AFEPC_IDX_SERVO, 32'h40);
    ahb_write(`AFEPC_IDX_DAC_R, 32'h123);
    ahb_write(`AFEPC_IDX_DAC_G, 32'h150);
    ahb_write(`AFEPC_IDX_DAC_B, 32'h180);
    settle(2);
    check_port(32'(offset_dac), 32'({10'h180, 10'h150, 10'h123}), "fw dacs");
    check_reg(`AFEPC_IDX_DAC_G, 32'h150);
    ahb_write(`AFEPC_IDX_GAIN_R, 32'h60);
    settle(5);
    check_port(32'(gain_live), 32'h555555, "gain before line");
    SRC.send_lines(1, 16);
    settle(10);
    check_port(32'(gain_live), 32'h555560, "gain after line");
    check_port(32'(offset_dac), 32'({10'h180, 10'h150, 10'h123}), "dacs after gain");
    $display("test firmware gain done");
  endtask

  task automatic t_servo();
    SRC.black_lvl = 24'h090005;
    ahb_write(`AFEPC_IDX_POWER, 32'h4);
    ahb_write(`AFEPC_IDX_SERVO, 32'h01);
    SRC.send_lines(64, 16);
    settle(20);
    check_port(32'(offset_dac[9:0]), 32'h121, "red steps down");
    check_port(32'(offset_dac[19:10]), 32'h150, "green holds");
    check_port(32'(offset_dac[29:20]), 32'h180, "blue powered down");
    ahb_write(`AFEPC_IDX_OFS_R, 32'h90);
    SRC.send_lines(64, 16);
    settle(20);
    check_port(32'(offset_dac[9:0]), 32'h123, "red steps up");
    ahb_write(`AFEPC_IDX_SERVO, 32'h05);
    SRC.send_lines(64, 16);
    settle(20);
    check_port(32'(offset_dac[9:0]), 32'h123, "short lines ignored");
    $display("test servo done");
  endtask

  initial begin
    miscompares = 0;
    n_tests     = 0;
    hresetn     = 1'b0;
    hsel        = 1'b1;
    haddr       = 32'h0;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'b010;
    hwdata      = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_power();
    t_tune_clamp();
    t_fw_gain();
    t_servo();
    stop_test();
  end
endmodule // tb_afe_power_clamp_black_level_control
